//--- src/smx_pkg.sv
// shared constants, types and decode helpers of the switch matrix config bank
package smx_pkg;

	// geometry
	localparam int SMX_NSW = 6;
	localparam int SMX_DW = 13;
	localparam int SMX_AW = 8;
	localparam int SMX_CW = 4;

	// register offsets
	localparam logic [7:0] SMX_ADDR_CLUSTER = 8'h03;
	localparam logic [7:0] SMX_ADDR_WATCHDOG = 8'h04;
	localparam logic [7:0] SMX_ADDR_OVERRIDE = 8'h05;
	localparam logic [7:0] SMX_ADDR_GROUP_A = 8'h06;
	localparam logic [7:0] SMX_ADDR_GROUP_B = 8'h07;

	// field positions
	localparam int SMX_SEL_LSB = 0;
	localparam int SMX_SEL_MSB = 5;
	localparam int SMX_WD_EN_BIT = 12;

	// reset values
	localparam logic [5:0] SMX_CLUSTER_RST = 6'h01;
	localparam logic [5:0] SMX_FALLBACK_RST = 6'h00;
	localparam logic SMX_WD_EN_RST = 1'b0;
	localparam logic [5:0] SMX_OVERRIDE_RST = 6'h00;
	localparam logic [5:0] SMX_GROUP_A_RST = 6'h00;
	localparam logic [5:0] SMX_GROUP_B_RST = 6'h00;
	localparam logic [12:0] SMX_RDATA_RST = 13'h0000;
	localparam logic SMX_CLOSED_RST = 1'b1;
	localparam logic SMX_FAULT_N_RST = 1'b1;
	localparam logic SMX_PWM_RESET_RST = 1'b1;
	localparam logic SMX_RVALID_RST = 1'b0;

	// group codes carried by phase-shift and dimming-period group writes
	localparam logic [3:0] SMX_GRP_CODE_A = 4'h1;
	localparam logic [3:0] SMX_GRP_CODE_B = 4'h2;

	// watchdog trip state
	typedef enum logic [0:0] {
		SMX_WD_IDLE = 1'b0,
		SMX_WD_TRIPPED = 1'b1
	} smx_wd_state_t;

	// register access from the serial front end
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [12:0] wdata;
	} smx_reg_req_t;

	// group-addressed write strobes with their group code
	typedef struct packed {
		logic phase_wr;
		logic dim_wr;
		logic duty_a_wr;
		logic duty_b_wr;
		logic [3:0] code;
	} smx_grp_cmd_t;

	function automatic logic smx_code_match(input logic [3:0] code,
		input logic [3:0] target);
		return code == target;
	endfunction : smx_code_match

	function automatic logic smx_addr_hit(input smx_reg_req_t req,
		input logic [7:0] target);
		return req.addr == target;
	endfunction : smx_addr_hit

endpackage : smx_pkg

//--- src/smx_switch_lane.sv
// one switch lane: final switch state, fault gating and group hits
`timescale 1ns/1ns
module smx_switch_lane
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// control
	input wire logic switching_enable,
	input wire logic wd_active,
	input wire logic fallback_closed,
	input wire logic force_closed,
	input wire logic pwm_open,
	// group membership
	input wire logic member_a,
	input wire logic member_b,
	input wire smx_pkg::smx_grp_cmd_t grp,
	// results
	output logic switch_closed,
	output logic fault_eval_en,
	output logic phase_hit,
	output logic dim_hit,
	output logic duty_hit
);

	logic closed_q;
	logic closed_d;
	logic code_a;
	logic code_b;
	logic in_group;

	assign code_a = smx_pkg::smx_code_match(grp.code, smx_pkg::SMX_GRP_CODE_A);
	assign code_b = smx_pkg::smx_code_match(grp.code, smx_pkg::SMX_GRP_CODE_B);
	assign in_group = (member_a & code_a) | (member_b & code_b);

	assign phase_hit = grp.phase_wr & in_group;
	assign dim_hit = grp.dim_wr & in_group;
	assign duty_hit = (grp.duty_a_wr & member_a)
		| (grp.duty_b_wr & member_b);

	// disabled switching beats everything, fallback beats override
	assign closed_d = !switching_enable ? 1'b1
		: wd_active ? fallback_closed
		: force_closed ? 1'b1
		: !pwm_open;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			closed_q <= smx_pkg::SMX_CLOSED_RST;
		else
			closed_q <= closed_d;
	end

	assign switch_closed = closed_q;
	// faults only make sense across an open switch
	assign fault_eval_en = !closed_q;

endmodule : smx_switch_lane

//--- src/smx_config_regs.sv
// configuration bank of the six-switch bypass matrix: id, watchdog, groups
`timescale 1ns/1ns
// Summary of operation
// - six-bit cluster id resets to 1; cluster-call accepted only on id match
// - watchdog enabled plus uart timeout drives the low-active fault flag
// - on enabled timeout each switch takes its fallback bit, 1 closed
// - watchdog disabled: timeouts change no switch and raise no fault
// - set override bit holds its switch closed whatever duty or dimming says
// - led faults are evaluated only while the switch is open
// - group a members answer group-a duty and group code 0001 writes
// - group b members answer group-b duty and group code 0010 writes
// - switching disabled closes all switches and resets pwm counters
module smx_config_regs
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// register access from the serial front end
	input wire smx_pkg::smx_reg_req_t reg_req,
	output logic [12:0] reg_rdata,
	output logic reg_rvalid,
	// cluster-call qualification
	input wire logic cc_valid,
	input wire logic [5:0] cc_id,
	output logic cc_accept,
	// watchdog
	input wire logic uart_timeout,
	input wire logic timeout_clear,
	output logic wd_active,
	output logic fault_flag_n,
	// switching
	input wire logic switching_enable,
	input wire logic [5:0] pwm_open,
	output logic [5:0] switch_closed,
	output logic [5:0] fault_eval_en,
	output logic pwm_counter_reset,
	// group-addressed writes
	input wire smx_pkg::smx_grp_cmd_t grp_cmd,
	output logic [5:0] phase_hit,
	output logic [5:0] dim_hit,
	output logic [5:0] duty_hit
);

	// stored fields
	logic [5:0] cluster_id_q;
	logic [5:0] cluster_id_d;
	logic wd_enable_q;
	logic wd_enable_d;
	logic [5:0] fallback_q;
	logic [5:0] fallback_d;
	logic [5:0] force_closed_q;
	logic [5:0] force_closed_d;
	logic [5:0] group_a_q;
	logic [5:0] group_a_d;
	logic [5:0] group_b_q;
	logic [5:0] group_b_d;

	// read path
	logic [12:0] rdata_q;
	logic [12:0] rdata_d;
	logic rvalid_q;
	logic [12:0] rd_cluster;
	logic [12:0] rd_watchdog;
	logic [12:0] rd_override;
	logic [12:0] rd_group_a;
	logic [12:0] rd_group_b;

	// watchdog and fault flag
	smx_pkg::smx_wd_state_t wd_state_q;
	smx_pkg::smx_wd_state_t wd_state_d;
	logic fault_n_q;
	logic fault_n_d;
	logic pwm_reset_q;

	// address decode
	logic hit_cluster;
	logic hit_watchdog;
	logic hit_override;
	logic hit_group_a;
	logic hit_group_b;
	logic wr_cluster;
	logic wr_watchdog;
	logic wr_override;
	logic wr_group_a;
	logic wr_group_b;
	logic wd_trip;

	assign hit_cluster = smx_pkg::smx_addr_hit(reg_req,
		smx_pkg::SMX_ADDR_CLUSTER);
	assign hit_watchdog = smx_pkg::smx_addr_hit(reg_req,
		smx_pkg::SMX_ADDR_WATCHDOG);
	assign hit_override = smx_pkg::smx_addr_hit(reg_req,
		smx_pkg::SMX_ADDR_OVERRIDE);
	assign hit_group_a = smx_pkg::smx_addr_hit(reg_req,
		smx_pkg::SMX_ADDR_GROUP_A);
	assign hit_group_b = smx_pkg::smx_addr_hit(reg_req,
		smx_pkg::SMX_ADDR_GROUP_B);

	assign wr_cluster = reg_req.wr & hit_cluster;
	assign wr_watchdog = reg_req.wr & hit_watchdog;
	assign wr_override = reg_req.wr & hit_override;
	assign wr_group_a = reg_req.wr & hit_group_a;
	assign wr_group_b = reg_req.wr & hit_group_b;

	// the six-bit select field of a write word; upper bits are dropped
	function automatic logic [5:0] sel_field(input logic [12:0] w);
		return w[smx_pkg::SMX_SEL_MSB:smx_pkg::SMX_SEL_LSB];
	endfunction : sel_field

	// register word from its fields; other bits read as zero
	function automatic logic [12:0] read_word(input logic en,
		input logic [5:0] sel);
		logic [12:0] w;
		w = smx_pkg::SMX_RDATA_RST;
		w[smx_pkg::SMX_WD_EN_BIT] = en;
		w[smx_pkg::SMX_SEL_MSB:smx_pkg::SMX_SEL_LSB] = sel;
		return w;
	endfunction : read_word

	// next values of the stored fields
	assign cluster_id_d = wr_cluster
		? sel_field(reg_req.wdata)
		: cluster_id_q;
	assign wd_enable_d = wr_watchdog
		? reg_req.wdata[smx_pkg::SMX_WD_EN_BIT]
		: wd_enable_q;
	assign fallback_d = wr_watchdog
		? sel_field(reg_req.wdata)
		: fallback_q;
	assign force_closed_d = wr_override
		? sel_field(reg_req.wdata)
		: force_closed_q;
	assign group_a_d = wr_group_a
		? sel_field(reg_req.wdata)
		: group_a_q;
	assign group_b_d = wr_group_b
		? sel_field(reg_req.wdata)
		: group_b_q;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			cluster_id_q <= smx_pkg::SMX_CLUSTER_RST;
		else
			cluster_id_q <= cluster_id_d;
	end

	// enable and fallback share one register word
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wd_enable_q <= smx_pkg::SMX_WD_EN_RST;
			fallback_q <= smx_pkg::SMX_FALLBACK_RST;
		end
		else
		begin
			wd_enable_q <= wd_enable_d;
			fallback_q <= fallback_d;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			force_closed_q <= smx_pkg::SMX_OVERRIDE_RST;
		else
			force_closed_q <= force_closed_d;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			group_a_q <= smx_pkg::SMX_GROUP_A_RST;
		else
			group_a_q <= group_a_d;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			group_b_q <= smx_pkg::SMX_GROUP_B_RST;
		else
			group_b_q <= group_b_d;
	end

	// read words of the five mapped offsets
	assign rd_cluster = read_word(1'b0, cluster_id_q);
	assign rd_watchdog = read_word(wd_enable_q, fallback_q);
	assign rd_override = read_word(1'b0, force_closed_q);
	assign rd_group_a = read_word(1'b0, group_a_q);
	assign rd_group_b = read_word(1'b0, group_b_q);

	// unmapped offsets read as zero
	assign rdata_d = hit_cluster ? rd_cluster
		: hit_watchdog ? rd_watchdog
		: hit_override ? rd_override
		: hit_group_a ? rd_group_a
		: hit_group_b ? rd_group_b
		: smx_pkg::SMX_RDATA_RST;

	// read data holds until the next read
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdata_q <= smx_pkg::SMX_RDATA_RST;
			rvalid_q <= smx_pkg::SMX_RVALID_RST;
		end
		else
		begin
			rvalid_q <= reg_req.rd;
			if (reg_req.rd)
				rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;

	// cluster call qualified against the stored id
	assign cc_accept = cc_valid & (cc_id == cluster_id_q);

	// timeout only counts while the watchdog is enabled
	assign wd_trip = uart_timeout & wd_enable_q;

	// tripped state is sticky until cleared or the watchdog is disabled; a trip in
	// the clearing cycle wins so a late timeout is never lost
	always_comb
	begin
		case (wd_state_q)
			smx_pkg::SMX_WD_IDLE:
			begin
				if (wd_trip)
					wd_state_d = smx_pkg::SMX_WD_TRIPPED;
				else
					wd_state_d = smx_pkg::SMX_WD_IDLE;
			end
			smx_pkg::SMX_WD_TRIPPED:
			begin
				if (wd_trip)
					wd_state_d = smx_pkg::SMX_WD_TRIPPED;
				else if (timeout_clear || !wd_enable_q)
					wd_state_d = smx_pkg::SMX_WD_IDLE;
				else
					wd_state_d = smx_pkg::SMX_WD_TRIPPED;
			end
			default:
				wd_state_d = smx_pkg::SMX_WD_IDLE;
		endcase
	end

	// flag falls in the same cycle as the state goes tripped
	assign fault_n_d = (wd_state_d != smx_pkg::SMX_WD_TRIPPED);

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wd_state_q <= smx_pkg::SMX_WD_IDLE;
			fault_n_q <= smx_pkg::SMX_FAULT_N_RST;
		end
		else
		begin
			wd_state_q <= wd_state_d;
			fault_n_q <= fault_n_d;
		end
	end

	// counters are held while switching is off and start from zero after
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			pwm_reset_q <= smx_pkg::SMX_PWM_RESET_RST;
		else
			pwm_reset_q <= !switching_enable;
	end

	assign wd_active = (wd_state_q == smx_pkg::SMX_WD_TRIPPED);
	assign fault_flag_n = fault_n_q;
	assign pwm_counter_reset = pwm_reset_q;

	// one lane per switch; bit n serves switch n+1
	genvar gi;
	generate
		for (gi = 0; gi < smx_pkg::SMX_NSW; gi++)
		begin : g_lane
			smx_switch_lane u_lane
			(
				.clk_sys(clk_sys),
				.reset_n(reset_n),
				.switching_enable(switching_enable),
				.wd_active(wd_active),
				.fallback_closed(fallback_q[gi]),
				.force_closed(force_closed_q[gi]),
				.pwm_open(pwm_open[gi]),
				.member_a(group_a_q[gi]),
				.member_b(group_b_q[gi]),
				.grp(grp_cmd),
				.switch_closed(switch_closed[gi]),
				.fault_eval_en(fault_eval_en[gi]),
				.phase_hit(phase_hit[gi]),
				.dim_hit(dim_hit[gi]),
				.duty_hit(duty_hit[gi])
			);
		end
	endgenerate

endmodule : smx_config_regs

//--- verification/smx_config_regs_asserts.sv
// port assertions of the switch matrix config bank
`timescale 1ns/1ns
module smx_config_regs_chk
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// watched ports
	input wire smx_pkg::smx_reg_req_t reg_req,
	input wire logic cc_valid,
	input wire logic [5:0] cc_id,
	input wire logic cc_accept,
	input wire logic uart_timeout,
	input wire logic wd_active,
	input wire logic fault_flag_n,
	input wire logic switching_enable,
	input wire logic [5:0] switch_closed,
	input wire logic [5:0] fault_eval_en,
	input wire logic pwm_counter_reset,
	input wire smx_pkg::smx_grp_cmd_t grp_cmd,
	input wire logic [5:0] phase_hit
);
	logic [5:0] id_q, fb_q, ov_q, ga_q, gb_q;
	logic en_q;
	wire a_code = grp_cmd.code == smx_pkg::SMX_GRP_CODE_A;
	wire b_code = grp_cmd.code == smx_pkg::SMX_GRP_CODE_B;
	wire [5:0] grp_sel = ({6{a_code}} & ga_q) | ({6{b_code}} & gb_q);
	// own shadow of the bank, never read back from the design
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			id_q <= smx_pkg::SMX_CLUSTER_RST;
			{en_q, fb_q, ov_q, ga_q, gb_q} <= '0;
		end
		else if (reg_req.wr)
		begin
			case (reg_req.addr)
				8'h03: id_q <= reg_req.wdata[5:0];
				8'h04: {en_q, fb_q} <= {reg_req.wdata[12], reg_req.wdata[5:0]};
				8'h05: ov_q <= reg_req.wdata[5:0];
				8'h06: ga_q <= reg_req.wdata[5:0];
				8'h07: gb_q <= reg_req.wdata[5:0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	cc_match_a: assert property (
		cc_accept == (cc_valid && cc_id == id_q)) else $error("cc accept");
	flag_set_a: assert property (
		uart_timeout && en_q |=> !fault_flag_n && wd_active)
		else $error("no fault flag");
	trip_cause_a: assert property (
		$rose(wd_active) |-> $past(uart_timeout && en_q)) else $error("trip");
	fallback_a: assert property (
		$past(wd_active && switching_enable) |-> switch_closed == $past(fb_q))
		else $error("fallback state");
	off_close_a: assert property (
		!switching_enable |=> switch_closed == 6'h3f && pwm_counter_reset)
		else $error("disable state");
	eval_open_a: assert property (
		fault_eval_en == ~switch_closed) else $error("fault eval");
	override_a: assert property (
		$past(switching_enable && !wd_active)
		|-> (switch_closed & $past(ov_q)) == $past(ov_q)) else $error("override");
	group_hit_a: assert property (
		phase_hit == ({6{grp_cmd.phase_wr}} & grp_sel)) else $error("group hit");
	cover property (cc_accept);
	cover property (wd_active ##1 !wd_active);
	cover property (|phase_hit);
endmodule : smx_config_regs_chk

bind smx_config_regs smx_config_regs_chk i_smx_config_regs_chk (.clk_sys,
	.reset_n, .reg_req, .cc_valid, .cc_id, .cc_accept, .uart_timeout,
	.wd_active, .fault_flag_n, .switching_enable, .switch_closed,
	.fault_eval_en, .pwm_counter_reset, .grp_cmd, .phase_hit);

//--- verification/smx_host_model.sv
// host-side master of the internal register port
`timescale 1ns/1ns
module smx_host_model
(
	// clock
	input wire logic clk_sys,
	// register port
	output smx_pkg::smx_reg_req_t reg_req,
	input wire logic [12:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial reg_req = '0;
	// released fields are inverted so nothing stale passes for a value
	task automatic wr(input logic [7:0] a, input logic [12:0] d);
	@(posedge clk_sys);
	reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
	@(posedge clk_sys);
	reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : wr
	// missing valid yields unknown data, so the compare fails
	task automatic rd(input logic [7:0] a, output logic [12:0] d);
	@(posedge clk_sys);
	reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 13'h0000};
	@(posedge clk_sys);
	reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 13'h1fff};
	#1 d = reg_rvalid ? reg_rdata : 'x;
	endtask : rd
endmodule : smx_host_model

//--- verification/smx_config_regs_bench.sv
// self-checking bench of the switch matrix config bank
`timescale 1ns/1ns
module smx_config_regs_bench;
	logic clk_sys, reset_n, cc_valid, uart_timeout, timeout_clear, cc_accept;
	logic switching_enable, reg_rvalid, wd_active, fault_flag_n, pwm_counter_reset;
	logic [5:0] cc_id, pwm_open, switch_closed, fault_eval_en;
	logic [5:0] phase_hit, dim_hit, duty_hit;
	logic [12:0] reg_rdata, v;
	smx_pkg::smx_reg_req_t reg_req;
	smx_pkg::smx_grp_cmd_t grp_cmd;
	int n_fail, checked, cycles;
	smx_config_regs i_smx_config_regs (.clk_sys, .reset_n, .reg_req,
		.reg_rdata, .reg_rvalid, .cc_valid, .cc_id, .cc_accept, .uart_timeout,
		.timeout_clear, .wd_active, .fault_flag_n, .switching_enable, .pwm_open,
		.switch_closed, .fault_eval_en, .pwm_counter_reset, .grp_cmd,
		.phase_hit, .dim_hit, .duty_hit);
	smx_host_model i_smx_host_model (.clk_sys, .reg_req, .reg_rdata,
		.reg_rvalid);
	task automatic chk(input logic [12:0] s, input logic [12:0] e);
	checked++;
	if (s !== e)
	begin
		n_fail++;
		$display("Error at %0t: seen %h expected %h", $time, s, e);
	end
	endtask : chk
	task automatic close_out;
	$display("checks %0d mismatches %0d", checked, n_fail);
	if (n_fail == 0 && checked > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
	endtask : close_out
	task automatic cyc(input int n);
	repeat (n) @(posedge clk_sys);
	#1;
	endtask : cyc
	task automatic sw(input logic [5:0] e);
	chk({7'h00, switch_closed}, {7'h00, e});
	endtask : sw
	task automatic t_regs;
	logic [12:0] e;
	for (int a = 3; a < 9; a++)
	begin
		i_smx_host_model.rd(8'(a), v);
		chk(v, (a == 3) ? 13'h0001 : 13'h0000);
		i_smx_host_model.wr(8'(a), 13'h1fff);
		i_smx_host_model.rd(8'(a), v);
		e = (a == 8) ? 13'h0000 : (a == 4) ? 13'h103f : 13'h003f;
		chk(v, e);
	end
	endtask : t_regs
	task automatic t_cluster;
	i_smx_host_model.wr(8'h03, 13'h002a);
	@(posedge clk_sys);
	cc_valid <= 1'b1;
	cc_id <= 6'h2a;
	#1 chk({12'h000, cc_accept}, 13'h0001);
	@(posedge clk_sys);
	cc_id <= 6'h2b;
	#1 chk({12'h000, cc_accept}, 13'h0000);
	endtask : t_cluster
	task automatic t_watchdog(input logic en);
	i_smx_host_model.wr(8'h05, 13'h0000);
	i_smx_host_model.wr(8'h04, {en, 12'h015});
	@(posedge clk_sys);
	uart_timeout <= 1'b1;
	@(posedge clk_sys);
	uart_timeout <= 1'b0;
	cyc(5);
	sw(en ? 6'h15 : 6'h00);
	chk({12'h000, fault_flag_n}, {12'h000, !en});
	chk({12'h000, wd_active}, {12'h000, en});
	@(posedge clk_sys);
	timeout_clear <= 1'b1;
	@(posedge clk_sys);
	timeout_clear <= 1'b0;
	cyc(2);
	sw(6'h00);
	chk({12'h000, fault_flag_n}, 13'h0001);
	chk({12'h000, wd_active}, 13'h0000);
	if (en)
	begin
		@(posedge clk_sys);
		uart_timeout <= 1'b1;
		@(posedge clk_sys);
		uart_timeout <= 1'b0;
		i_smx_host_model.wr(8'h04, 13'h0015);
		cyc(1);
		chk({12'h000, wd_active}, 13'h0000);
		chk({12'h000, fault_flag_n}, 13'h0001);
	end
	endtask : t_watchdog
	task automatic t_override;
	i_smx_host_model.wr(8'h05, 13'h0009);
	cyc(2);
	sw(6'h09);
	chk({7'h00, fault_eval_en}, 13'h0036);
	i_smx_host_model.wr(8'h05, 13'h0000);
	endtask : t_override
	task automatic t_groups;
	logic [5:0] e;
	i_smx_host_model.wr(8'h06, 13'h0007);
	i_smx_host_model.wr(8'h07, 13'h000c);
	for (int c = 0; c < 4; c++)
	begin
		@(posedge clk_sys);
		grp_cmd <= '{1'b1, 1'b1, c[0], c[1], 4'(c)};
		#1 e = (c == 1) ? 6'h07 : (c == 2) ? 6'h0c : 6'h00;
		chk({7'h00, phase_hit}, {7'h00, e});
		chk({7'h00, dim_hit}, {7'h00, e});
		e = (c[0] ? 6'h07 : 6'h00) | (c[1] ? 6'h0c : 6'h00);
		chk({7'h00, duty_hit}, {7'h00, e});
	end
	@(posedge clk_sys);
	grp_cmd <= '0;
	endtask : t_groups
	task automatic t_disable(input logic en);
	@(posedge clk_sys);
	switching_enable <= en;
	cyc(2);
	sw(en ? 6'h00 : 6'h3f);
	chk({12'h000, pwm_counter_reset}, {12'h000, !en});
	endtask : t_disable
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			close_out;
		end
	end
	initial
	begin
		{reset_n, cc_valid, uart_timeout, timeout_clear, cc_id, grp_cmd} = '0;
		switching_enable = 1'b1;
		pwm_open = 6'h3f;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_regs;
		t_cluster;
		t_watchdog(1'b1);
		t_watchdog(1'b0);
		t_override;
		t_groups;
		t_disable(1'b0);
		t_disable(1'b1);
		close_out;
	end
endmodule : smx_config_regs_bench
